/* File: acr_pkg.sv */
// package of constants and types for the converter control/status block
package acr_pkg;
  localparam int unsigned ACR_DW = 8;
  localparam int unsigned ACR_AW = 8;
  // register addresses
  localparam logic [7:0] ACR_ADDR_CTRL_ONE = 8'h9f;
  localparam logic [7:0] ACR_ADDR_CTRL_TWO = 8'ha0;
  localparam logic [7:0] ACR_ADDR_RESULT = 8'ha1;
  // control one field positions
  localparam int unsigned ACR_BIT_PEND = 7;
  localparam int unsigned ACR_BIT_IRQEN = 6;
  localparam int unsigned ACR_BIT_START = 5;
  localparam int unsigned ACR_BIT_REF = 4;
  localparam int unsigned ACR_CHAN_HI = 3;
  // control two field positions used here
  localparam int unsigned ACR_BIT_AUTOSAMPLE = 4;
  localparam int unsigned ACR_BIT_AUTOZERO = 0;
  // reset values
  localparam logic [7:0] ACR_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] ACR_RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] ACR_RST_RESULT = 8'h00;
  // conversion lengths in conversion-clock cycles
  localparam logic [4:0] ACR_CONV_STD = 5'h0d;
  localparam logic [4:0] ACR_CONV_AZ = 5'h14;
  // conversion clock divider (one-cycle enable pulse)
  localparam logic [3:0] ACR_CCLK_DIV = 4'h4;
  // channel codes selecting the one-hot mux lines
  localparam logic [3:0] ACR_CH_ONE = 4'h0;
  localparam logic [3:0] ACR_CH_TWO = 4'h1;
  localparam logic [3:0] ACR_CH_THREE = 4'h2;
  localparam logic [3:0] ACR_CH_FOUR = 4'h3;
  localparam logic [3:0] ACR_CH_FIVE = 4'h8;
  localparam logic [3:0] ACR_CH_GND = 4'h9;
  localparam logic [3:0] ACR_CH_VREF = 4'ha;
  localparam logic [3:0] ACR_CH_VCC3 = 4'hc;

  typedef enum logic [1:0] {ACR_IDLE, ACR_CONV, ACR_LATCH} acr_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acr_bus_req_t;

  typedef struct packed {
    logic [7:0] mux_sel;
    logic ref_supply;
    logic autozero;
    logic conv_start;
    logic conv_busy;
  } acr_analog_t;

  typedef struct packed {
    acr_state_t st;
    logic pend;
    logic irq_en;
    logic ref_sel;
    logic [3:0] chan;
    logic [7:0] ctrl_two;
    logic [7:0] result;
    logic [3:0] chan_live;
    logic ref_live;
    logic az_live;
    logic [4:0] cyc;
    logic [3:0] div;
    logic [2:0] strobe_sync;
    logic strobe_last;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] mux;
    logic start_p;
    logic busy;
  } acr_state_s_t;
endpackage

/* File: acr_regs.sv */
// control and status registers for the 8-bit converter
//
// How it works
// - result register is read-only, loaded with the 8-bit value each conversion end
// - pending flag in bit 7 sets once the result is latched
// - interrupt request stays high while enabled and pending is set
// - without auto-sampling, conversions start only on software writing start bit 1
// - start/busy reads 1 for the whole conversion, clears itself at the end
// - writing 0 to start/busy during conversion is ignored
// - reference select 0 picks bandgap, 1 picks the supply
// - channel select captured at trigger and held until the conversion ends
// - channel read-back returns last written value, not the applied selection
// - channel codes map to five inputs, ground, reference and supply third
// - writing 1 to pending keeps it, writing 0 clears it
// - all eight control bits are readable and writable, with pending/busy exceptions
// - with auto-sampling enabled, timer strobe rising edge triggers conversions
// - standard conversion takes 13 conversion clocks, autozero 20
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire acr_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic conv_irq,
  input wire logic timer_conv_strobe,
  input wire logic [7:0] conv_data,
  output acr_analog_t analog_out
);
  acr_state_s_t s_q;
  acr_state_s_t s_d;
  logic wr_one;
  logic wr_two;
  logic trig_sw;
  logic trig_hw;
  logic trig;
  logic busy;
  logic cclk_en;
  logic [4:0] conv_len;

  always_comb begin
    busy = (s_q.st != ACR_IDLE);
    wr_one = bus_req.wr && (bus_req.addr == ACR_ADDR_CTRL_ONE);
    wr_two = bus_req.wr && (bus_req.addr == ACR_ADDR_CTRL_TWO);
    cclk_en = (s_q.div == ACR_CCLK_DIV - 4'h1);
    // a start write in auto-sampling mode is not a trigger
    trig_sw = wr_one && bus_req.wdata[ACR_BIT_START] && !s_q.ctrl_two[ACR_BIT_AUTOSAMPLE];
    // the strobe counts as risen once the second and third sync stages agree high
    trig_hw = s_q.ctrl_two[ACR_BIT_AUTOSAMPLE] && s_q.strobe_sync[2] && s_q.strobe_sync[1]
      && !s_q.strobe_last;
    trig = !busy && (trig_sw || trig_hw);
    conv_len = s_q.az_live ? ACR_CONV_AZ : ACR_CONV_STD;
  end

  always_comb begin
    s_d = s_q;
    s_d.start_p = 1'b0;
    s_d.strobe_sync = {s_q.strobe_sync[1:0], timer_conv_strobe};
    // only a level that two stages agree on becomes the settled strobe level
    if (s_q.strobe_sync[2] == s_q.strobe_sync[1]) begin
      s_d.strobe_last = s_q.strobe_sync[2];
    end
    s_d.div = cclk_en ? 4'h0 : s_q.div + 4'h1;
    if (wr_one) begin
      s_d.irq_en = bus_req.wdata[ACR_BIT_IRQEN];
      s_d.ref_sel = bus_req.wdata[ACR_BIT_REF];
      s_d.chan = bus_req.wdata[ACR_CHAN_HI:0];
      if (!bus_req.wdata[ACR_BIT_PEND]) begin
        s_d.pend = 1'b0;
      end
    end
    if (wr_two) begin
      s_d.ctrl_two = bus_req.wdata;
    end
    case (s_q.st)
      ACR_IDLE: begin
        if (trig) begin
          s_d.st = ACR_CONV;
          s_d.cyc = 5'h00;
          s_d.start_p = 1'b1;
          // capture selections from the latest written values
          s_d.chan_live = wr_one ? bus_req.wdata[ACR_CHAN_HI:0] : s_q.chan;
          s_d.ref_live = wr_one ? bus_req.wdata[ACR_BIT_REF] : s_q.ref_sel;
          s_d.az_live = wr_two ? bus_req.wdata[ACR_BIT_AUTOZERO] : s_q.ctrl_two[ACR_BIT_AUTOZERO];
        end
      end
      ACR_CONV: begin
        if (cclk_en) begin
          s_d.cyc = s_q.cyc + 5'h01;
          if (s_q.cyc == conv_len - 5'h01) begin
            s_d.st = ACR_LATCH;
          end
        end
      end
      ACR_LATCH: begin
        s_d.result = conv_data;
        s_d.pend = 1'b1;
        s_d.st = ACR_IDLE;
      end
      default: begin
        s_d.st = ACR_IDLE;
      end
    endcase
    s_d.irq = s_d.pend && s_d.irq_en;
    s_d.busy = (s_d.st != ACR_IDLE);
    case (s_d.chan_live)
      ACR_CH_ONE: s_d.mux = 8'h01;
      ACR_CH_TWO: s_d.mux = 8'h02;
      ACR_CH_THREE: s_d.mux = 8'h04;
      ACR_CH_FOUR: s_d.mux = 8'h08;
      ACR_CH_FIVE: s_d.mux = 8'h10;
      ACR_CH_GND: s_d.mux = 8'h20;
      ACR_CH_VREF: s_d.mux = 8'h40;
      ACR_CH_VCC3: s_d.mux = 8'h80;
      default: s_d.mux = 8'h00;
    endcase
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ACR_ADDR_CTRL_ONE: s_d.rdata = {s_q.pend, s_q.irq_en, busy, s_q.ref_sel, s_q.chan};
        ACR_ADDR_CTRL_TWO: s_d.rdata = s_q.ctrl_two;
        ACR_ADDR_RESULT: s_d.rdata = s_q.result;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ACR_IDLE;
      s_q.ctrl_two <= ACR_RST_CTRL_TWO;
      s_q.result <= ACR_RST_RESULT;
      s_q.mux <= 8'h01;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign conv_irq = s_q.irq;
  assign analog_out.mux_sel = s_q.mux;
  assign analog_out.ref_supply = s_q.ref_live;
  assign analog_out.autozero = s_q.az_live;
  assign analog_out.conv_start = s_q.start_p;
  assign analog_out.conv_busy = s_q.busy;

  // interrupt request follows pending and enable in the same cycle
  AST_IRQ_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.pend && s_q.irq_en) |-> conv_irq)
    else $error("irq not raised");
  AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s_q.pend || !s_q.irq_en) |-> !conv_irq)
    else $error("irq without pending");

  // result and pending flag
  AST_PEND_ON_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_LATCH) |=> (s_q.pend && s_q.result == $past(conv_data)))
    else $error("no latch");
  AST_RESULT_RO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st != ACR_LATCH) |=> $stable(s_q.result))
    else $error("result changed outside latch");
  AST_OVERWRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_LATCH && s_q.pend) |=> (s_q.pend && s_q.result == $past(conv_data)))
    else $error("result not overwritten");

  // triggers
  AST_SW_TRIG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_IDLE && wr_one && bus_req.wdata[ACR_BIT_START] && !s_q.ctrl_two[ACR_BIT_AUTOSAMPLE])
    |=> analog_out.conv_start) else $error("sw start ignored");
  AST_NO_SW_AUTO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_IDLE && s_q.ctrl_two[ACR_BIT_AUTOSAMPLE] && !trig_hw) |=> s_q.st == ACR_IDLE)
    else $error("sw start in auto");
  AST_HW_TRIG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_IDLE && trig_hw) |=> analog_out.conv_start)
    else $error("strobe ignored");

  // start/busy bit
  AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
    analog_out.conv_start |-> analog_out.conv_busy)
    else $error("start without busy");
  AST_BUSY_ENDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_LATCH) |=> !analog_out.conv_busy)
    else $error("busy not cleared");
  AST_BUSY_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ACR_ADDR_CTRL_ONE) |=> (bus_rdata[ACR_BIT_START] == $past(analog_out.conv_busy)))
    else $error("busy bit read wrong");
  AST_BUSY_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV && wr_one && !bus_req.wdata[ACR_BIT_START]) |=> analog_out.conv_busy)
    else $error("busy cleared");
  AST_NO_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st != ACR_IDLE) |=> !analog_out.conv_start)
    else $error("restart while busy");

  // selections frozen at the trigger
  AST_CHAN_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV && $past(s_q.st) == ACR_CONV) |-> $stable(s_q.chan_live))
    else $error("chan moved");
  AST_REF_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV && $past(s_q.st) == ACR_CONV) |-> $stable(analog_out.ref_supply))
    else $error("reference moved");
  AST_CHAN_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_one |=> (s_q.chan == $past(bus_req.wdata[ACR_CHAN_HI:0])))
    else $error("chan readback lost");
  AST_MUX_FIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st != ACR_IDLE && s_q.chan_live == ACR_CH_FIVE) |-> analog_out.mux_sel[4])
    else $error("channel five not selected");

  // pending flag and control field write rules
  AST_NO_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s_q.pend && s_q.st != ACR_LATCH) |=> !s_q.pend)
    else $error("pend set by sw");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_one && !bus_req.wdata[ACR_BIT_PEND] && s_q.st != ACR_LATCH) |=> !s_q.pend)
    else $error("no clear");
  AST_PEND_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_one && bus_req.wdata[ACR_BIT_PEND] && s_q.pend) |=> s_q.pend)
    else $error("pend lost on write one");
  AST_CTRL_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_one |=> (s_q.irq_en == $past(bus_req.wdata[ACR_BIT_IRQEN]) && s_q.ref_sel == $past(bus_req.wdata[ACR_BIT_REF])))
    else $error("control write lost");

  // conversion length
  AST_CYC_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV && !cclk_en) |=> $stable(s_q.cyc))
    else $error("count moved without enable");
  AST_LEN_EXIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV && cclk_en && s_q.cyc == conv_len - 5'h01) |=> (s_q.st == ACR_LATCH))
    else $error("conversion overran");
  AST_LEN_STD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.st == ACR_CONV) |-> (s_q.cyc < conv_len))
    else $error("too long");
endmodule

/* File: acr_conv_model.sv */
// behavioural converter core that answers each conversion with a fresh value
`timescale 1ns/1ps
module acr_conv_model (
  input wire logic core_clk,
  input wire logic conv_start,
  input wire logic conv_busy,
  output logic [7:0] conv_data
);
  logic [7:0] val_q = 8'h5a;
  logic [7:0] noise_q = 8'h00;
  always_ff @(posedge core_clk) begin
    noise_q <= noise_q + 8'h01;
    if (conv_start) begin
      val_q <= val_q + 8'h3b;
    end
  end
  // outside a conversion the line never shows the held value
  assign conv_data = conv_busy ? val_q : (~val_q ^ {noise_q[6:0], 1'b0});
endmodule

/* File: acr_tb.sv */
// self-checking testbench for the converter control and status registers
`timescale 1ns/1ps
module testbench;
  import acr_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic timer_conv_strobe = 1'b0;
  acr_bus_req_t req = '0;
  logic [7:0] bus_rdata, conv_data, rv;
  logic [7:0] exp_v = 8'h5a;
  logic conv_irq;
  acr_analog_t ana;
  logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hc};
  int bad_count = 0;
  int samples_checked = 0;
  always #2 core_clk = ~core_clk;
  acr_regs acr_regs_i (.core_clk(core_clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(bus_rdata),
    .conv_irq(conv_irq), .timer_conv_strobe(timer_conv_strobe), .conv_data(conv_data), .analog_out(ana));
  acr_conv_model acr_conv_model_i (.core_clk(core_clk), .conv_start(ana.conv_start),
    .conv_busy(ana.conv_busy), .conv_data(conv_data));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk) req <= '0;
  endtask
  task automatic rd_raw(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk) req <= '0;
    #1 v = bus_rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    rd_raw(a, v);
    chk(n, v, e);
  endtask
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && ana.conv_busy !== lvl; i++) begin
      @(posedge core_clk);
    end
    if (i == 200) begin
      chk("busy_wait", {7'h00, ~lvl}, {7'h00, lvl});
      finish_test();
    end
  endtask
  task automatic conv_end();
    int i;
    rv = 8'hff;
    // software view: poll the start/busy bit, not the pending flag
    for (i = 0; i < 100 && rv[ACR_BIT_START] !== 1'b0; i++) begin
      rd_raw(ACR_ADDR_CTRL_ONE, rv);
    end
    if (i == 100) begin
      chk("busy_poll", {7'h00, rv[ACR_BIT_START]}, 8'h00);
      finish_test();
    end
    chk("busy_pin", {7'h00, ana.conv_busy}, 8'h00);
    chk("pend_at_done", {7'h00, rv[ACR_BIT_PEND]}, 8'h01);
    exp_v = exp_v + 8'h3b;
    rd(ACR_ADDR_RESULT, exp_v, "result");
  endtask
  task automatic t_reset();
    rd(ACR_ADDR_CTRL_ONE, 8'h00, "ctrl_one_rst");
    rd(ACR_ADDR_RESULT, 8'h00, "result_rst");
    rd(8'hb0, 8'h00, "unmapped");
    chk("mux_rst", ana.mux_sel, 8'h01);
    chk("irq_rst", {7'h00, conv_irq}, 8'h00);
    chk("busy_rst", {7'h00, ana.conv_busy}, 8'h00);
    chk("ref_rst", {7'h00, ana.ref_supply}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_conv();
    wr(ACR_ADDR_CTRL_ONE, 8'h73);
    wait_busy(1'b1);
    repeat (2) @(posedge core_clk);
    #1 chk("mux_sel", ana.mux_sel, 8'h08);
    chk("ref_supply", {7'h00, ana.ref_supply}, 8'h01);
    rd(ACR_ADDR_CTRL_ONE, 8'h73, "busy_read");
    // channel rewritten to 1 and start written 0; reference bit keeps its running value
    wr(ACR_ADDR_CTRL_ONE, 8'h51);
    rd(ACR_ADDR_CTRL_ONE, 8'h71, "busy_kept");
    #1 chk("mux_held", ana.mux_sel, 8'h08);
    conv_end();
    chk("irq", {7'h00, conv_irq}, 8'h01);
    rd(ACR_ADDR_CTRL_ONE, 8'hd1, "pend_set");
    wr(ACR_ADDR_CTRL_ONE, 8'hd1);
    rd(ACR_ADDR_CTRL_ONE, 8'hd1, "pend_hold");
    wr(ACR_ADDR_CTRL_ONE, 8'h11);
    rd(ACR_ADDR_CTRL_ONE, 8'h11, "pend_clear");
    chk("irq_off", {7'h00, conv_irq}, 8'h00);
    $display("test conversion done");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      wr(ACR_ADDR_CTRL_ONE, {4'ha, codes[i]});
      wait_busy(1'b1);
      repeat (2) @(posedge core_clk);
      #1 chk("mux_code", ana.mux_sel, 8'h01 << i);
      chk("ref_gap", {7'h00, ana.ref_supply}, 8'h00);
      conv_end();
    end
    rd(ACR_ADDR_CTRL_ONE, 8'h8c, "pend_overrun");
    $display("test channel codes done");
  endtask
  task automatic t_auto();
    wr(ACR_ADDR_CTRL_TWO, 8'h10);
    wr(ACR_ADDR_CTRL_ONE, 8'h20);
    repeat (4) @(posedge core_clk);
    #1 chk("sw_start_ignored", {7'h00, ana.conv_busy}, 8'h00);
    @(posedge core_clk) timer_conv_strobe <= 1'b1;
    wait_busy(1'b1);
    conv_end();
    @(posedge core_clk) timer_conv_strobe <= 1'b0;
    wr(ACR_ADDR_CTRL_TWO, 8'h00);
    $display("test auto sampling done");
  endtask
  task automatic t_len();
    int az;
    int n;
    int lo;
    int hi;
    logic [4:0] len;
    for (az = 0; az < 2; az++) begin
      len = (az == 1) ? ACR_CONV_AZ : ACR_CONV_STD;
      // the first divided enable falls one to four core cycles after the trigger
      lo = int'(ACR_CCLK_DIV) * (int'(len) - 1) + 2;
      hi = int'(ACR_CCLK_DIV) * int'(len) + 1;
      wr(ACR_ADDR_CTRL_TWO, {7'h00, az[0]});
      rd(ACR_ADDR_CTRL_TWO, {7'h00, az[0]}, "ctrl_two");
      wr(ACR_ADDR_CTRL_ONE, 8'h20);
      wait_busy(1'b1);
      chk("autozero", {7'h00, ana.autozero}, {7'h00, az[0]});
      n = 0;
      while (n < 200 && ana.conv_busy === 1'b1) begin
        @(posedge core_clk);
        n++;
      end
      chk("conv_len", {7'h00, (n >= lo && n <= hi)}, 8'h01);
      conv_end();
    end
    wr(ACR_ADDR_CTRL_TWO, 8'h00);
    $display("test conversion length done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_codes();
    t_auto();
    t_len();
    finish_test();
  end
endmodule
